// >>> hdl/loop_act_pkg.sv
// Purpose: shared constants for the loop activation state machine
// Assumes: 250 MHz mclk, timers run on a 1 ms local tick
// Notes: register offsets are byte addresses on the plain register port
package loop_act_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS = 1000000; // local timebase tick, 1 ms
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int PEND_TIME_MS = 2000; // 2 seconds
   localparam int LOSS_TIME_MS = 1000; // 1 second
   localparam int TICK_MS = 1;
   localparam int PEND_TICKS = PEND_TIME_MS / TICK_MS;
   localparam int LOSS_TICKS = LOSS_TIME_MS / TICK_MS;
   localparam int ACT_TIME_MS = 30000; // activation timer default
   localparam int ACT_TICKS = ACT_TIME_MS / TICK_MS;
   localparam int READY_FRAMES = 6; // consecutive frames to qualify
   // ==========================================================
   // register map
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam int CTRL_ACTIVATION_REQUEST = 0;
   localparam int CTRL_QUIET = 1;
   localparam int CTRL_CLR_SYNCTO = 2;
   localparam int CTRL_CLR_SIGTO = 3;
   localparam int STAT_SWL = 8;
   localparam int STAT_SIGL = 9;
   localparam int STAT_SYNCTO = 10;
   localparam int STAT_SIGTO = 11;
   localparam int STAT_CHB = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ==========================================================
   // coefficient frame marker symbols
   localparam logic [1:0] SYM_C = 2'h2;
   localparam logic [1:0] SYM_D = 2'h3;
   // ==========================================================
   // states, one-hot
   typedef enum logic [7:0] {
      ST_SELFTEST = 8'h01,
      ST_INACTIVE = 8'h02,
      ST_ACTIVATING = 8'h04,
      ST_ACT_RX = 8'h08,
      ST_ACT_TX = 8'h10,
      ST_ACT_TXRX = 8'h20,
      ST_PEND_DEACT = 8'h40,
      ST_DEACT = 8'h80
   } act_state_t;
endpackage

// >>> hdl/loop_activation_fsm.sv
// Purpose: loop activation state machine for either end of a copper pair
// Assumes: all inputs synchronous to mclk; frameStrobe pulses once per received line frame
// Notes: LINE_END selects line-end or network-end behaviour
// Behaviour
// - silence command deactivates, ignored when inactive or in self test
// - leave power-up only after self tests
// - network end: six frames qualify line-end-ready
// - line end: six frames qualify network-end-ready
// - network inactive: silent, flags set, startup wakes
// - network activating: timer, respond on arrival channel
// - network clears sync-word-lost on sync word
// - network activating: own ready Rx, far Tx
// - network timer expiry before sync deactivates
// - network Active-Rx indicators, exits to Tx/Rx
// - network Active-Tx indicators, exits to Tx/Rx
// - Tx/Rx stops timer; sync loss pends
// - pending: 2 s timer, regain or timeout
// - network deactivated: silent, waits signal lost
// - line inactive: silent, request starts activation
// - line sends startup; timer on far startup
// - line activating: sync clears, ready, expiry
// - line Active-Rx indicators, exits to Tx/Rx
// - line Active-Tx indicators, exits to Tx/Rx
// - line deactivated: 1 s loss timer, flag
// - network adopts pair identity, maps frames
// - regenerator holds startup until timing stable
// - inactive with request held retrains fully
// - marker CD means channel A, DC B
`timescale 1ns/10ps
module loop_activation_fsm #(
   parameter bit LINE_END = 1'b1,
   parameter bit IS_REGEN = 1'b0,
   parameter bit PAIR_IS_B = 1'b0,
   parameter int TICK_CYC = loop_act_pkg::TICK_CYCLES,
   parameter int ACT_TICKS = loop_act_pkg::ACT_TICKS,
   parameter int PEND_TICKS = loop_act_pkg::PEND_TICKS,
   parameter int LOSS_TICKS = loop_act_pkg::LOSS_TICKS
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic selfTestDone,
   input wire logic startupDetected,
   input wire logic startupOnB,
   input wire logic frameSyncOk,
   input wire logic frameStrobe,
   input wire logic farReadyBit,
   input wire logic localReady,
   input wire logic signalPresent,
   input wire logic timingStable,
   input wire logic markerValid,
   input wire logic [1:0] markerFirst,
   input wire logic [1:0] markerSecond,
   output logic [7:0] stateOut,
   output logic txSilent,
   output logic txStartup,
   output logic txFramed,
   output logic txOnB,
   output logic ownReadyInd,
   output logic farReadyInd,
   output logic syncWordLost,
   output logic signalLost,
   output logic syncLossTimeoutFlag,
   output logic signalLossTimeoutFlag,
   output logic pairIsB,
   output logic actTimerRunning
);
   // ==========================================================
   // register port
   logic [31:0] ctrl_r;
   logic [31:0] rdData_r;
   logic quietPulse;
   logic activationRequest;
   logic clrSyncTo;
   logic clrSigTo;
   wire ctrlHit = regAddr == loop_act_pkg::CTRL_OFS;
   wire statHit = regAddr == loop_act_pkg::STAT_OFS;
   wire ctrlWr = regWr && ctrlHit;
   // write side effects are one-cycle pulses
   assign quietPulse = ctrlWr && regWrData[loop_act_pkg::CTRL_QUIET];
   assign clrSyncTo = ctrlWr && regWrData[loop_act_pkg::CTRL_CLR_SYNCTO];
   assign clrSigTo = ctrlWr && regWrData[loop_act_pkg::CTRL_CLR_SIGTO];
   assign activationRequest = ctrl_r[loop_act_pkg::CTRL_ACTIVATION_REQUEST];

   logic [31:0] statWord;
   logic [31:0] rdSel;
   assign statWord = {19'h0, pairIsB, signalLossTimeoutFlag, syncLossTimeoutFlag,
                      signalLost, syncWordLost, stateOut};
   assign rdSel = ctrlHit ? ctrl_r : (statHit ? statWord : 32'h0000_0000);

   // control latch and read data one cycle later
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_r <= loop_act_pkg::CTRL_RESET;
         rdData_r <= 32'h0000_0000;
      end else begin
         if (ctrlWr) begin
            ctrl_r <= {31'h0, regWrData[loop_act_pkg::CTRL_ACTIVATION_REQUEST]};
         end
         rdData_r <= regRd ? rdSel : 32'h0000_0000;
      end
   end
   assign regRdData = rdData_r;

   // ==========================================================
   // local timebase
   logic [17:0] tickCnt_r;
   logic tick;
   assign tick = tickCnt_r == 18'(TICK_CYC - 1);
   always_ff @(posedge mclk) begin
      if (srst || tick) begin
         tickCnt_r <= 18'h0;
      end else begin
         tickCnt_r <= tickCnt_r + 18'h1;
      end
   end

   // ==========================================================
   // far ready qualification over consecutive frames
   loop_act_pkg::act_state_t state_r, state_nxt;
   logic [2:0] readyCnt_r;
   logic farReadyQ;
   logic readyClr;
   assign farReadyQ = readyCnt_r == 3'(loop_act_pkg::READY_FRAMES);
   // no line frames while idle, so a qualification left from an earlier session is dropped
   assign readyClr = state_r == loop_act_pkg::ST_INACTIVE || state_r == loop_act_pkg::ST_DEACT;
   always_ff @(posedge mclk) begin
      if (srst || readyClr) begin
         readyCnt_r <= 3'h0;
      end else if (frameStrobe) begin
         if (!farReadyBit) begin
            readyCnt_r <= 3'h0;
         end else if (!farReadyQ) begin
            readyCnt_r <= readyCnt_r + 3'h1;
         end
      end
   end

   // ==========================================================
   // state and timers
   logic syncWordLost_r, signalLost_r, syncTo_r, sigTo_r;
   logic actRun_r, actRun_nxt;
   logic [15:0] actCnt_r;
   logic [10:0] holdCnt_r;
   logic actExpire;
   logic pendExpire;
   logic lossExpire;
   logic holdRun;
   logic stateChange;
   assign stateChange = state_nxt != state_r;
   assign actExpire = actRun_r && tick && actCnt_r == 16'(ACT_TICKS - 1);
   // hold timer runs in pending, and in line-end deactivated without power
   assign holdRun = state_r == loop_act_pkg::ST_PEND_DEACT ||
                    (LINE_END && state_r == loop_act_pkg::ST_DEACT && !signalPresent);
   assign pendExpire = state_r == loop_act_pkg::ST_PEND_DEACT && tick &&
                       holdCnt_r == 11'(PEND_TICKS - 1);
   assign lossExpire = LINE_END && state_r == loop_act_pkg::ST_DEACT && !signalPresent &&
                       tick && holdCnt_r == 11'(LOSS_TICKS - 1);

   // next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         loop_act_pkg::ST_SELFTEST: begin
            if (selfTestDone) begin
               state_nxt = loop_act_pkg::ST_INACTIVE;
            end
         end
         loop_act_pkg::ST_INACTIVE: begin
            if (LINE_END ? activationRequest : startupDetected) begin
               state_nxt = loop_act_pkg::ST_ACTIVATING;
            end
         end
         loop_act_pkg::ST_ACTIVATING: begin
            if (actExpire && (LINE_END || syncWordLost_r)) begin
               state_nxt = loop_act_pkg::ST_DEACT;
            end else if (localReady) begin
               state_nxt = loop_act_pkg::ST_ACT_RX;
            end else if (farReadyQ) begin
               state_nxt = loop_act_pkg::ST_ACT_TX;
            end
         end
         loop_act_pkg::ST_ACT_RX: begin
            if (farReadyQ || actExpire) begin
               state_nxt = loop_act_pkg::ST_ACT_TXRX;
            end
         end
         loop_act_pkg::ST_ACT_TX: begin
            if (localReady || actExpire) begin
               state_nxt = loop_act_pkg::ST_ACT_TXRX;
            end
         end
         loop_act_pkg::ST_ACT_TXRX: begin
            if (!frameSyncOk) begin
               state_nxt = loop_act_pkg::ST_PEND_DEACT;
            end
         end
         loop_act_pkg::ST_PEND_DEACT: begin
            if (frameSyncOk) begin
               state_nxt = loop_act_pkg::ST_ACT_TXRX;
            end else if (pendExpire) begin
               state_nxt = loop_act_pkg::ST_DEACT;
            end
         end
         loop_act_pkg::ST_DEACT: begin
            if (LINE_END ? lossExpire : !signalPresent) begin
               state_nxt = loop_act_pkg::ST_INACTIVE;
            end
         end
         default: begin
            state_nxt = loop_act_pkg::ST_SELFTEST;
         end
      endcase
      // silence command overrides all but inactive and self test
      if (quietPulse && state_r != loop_act_pkg::ST_INACTIVE &&
          state_r != loop_act_pkg::ST_SELFTEST) begin
         state_nxt = loop_act_pkg::ST_DEACT;
      end
   end

   // activation timer run control
   always_comb begin
      actRun_nxt = actRun_r;
      if (state_nxt == loop_act_pkg::ST_ACTIVATING && state_r == loop_act_pkg::ST_INACTIVE) begin
         actRun_nxt = !LINE_END;
      end else if (LINE_END && state_r == loop_act_pkg::ST_ACTIVATING && startupDetected) begin
         actRun_nxt = 1'b1;
      end
      if (state_nxt != loop_act_pkg::ST_ACTIVATING && state_nxt != loop_act_pkg::ST_ACT_RX &&
          state_nxt != loop_act_pkg::ST_ACT_TX) begin
         actRun_nxt = 1'b0;
      end
   end

   // state and timer registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= loop_act_pkg::ST_SELFTEST;
         actRun_r <= 1'b0;
         actCnt_r <= 16'h0;
         holdCnt_r <= 11'h0;
      end else begin
         state_r <= state_nxt;
         actRun_r <= actRun_nxt;
         actCnt_r <= !actRun_r ? 16'h0 : (tick ? actCnt_r + 16'h1 : actCnt_r);
         holdCnt_r <= (!holdRun || stateChange) ? 11'h0 : (tick ? holdCnt_r + 11'h1 : holdCnt_r);
      end
   end

   // ==========================================================
   // flags
   logic swl_nxt, sigl_nxt;
   always_comb begin
      swl_nxt = syncWordLost_r;
      sigl_nxt = signalLost_r;
      unique case (state_nxt)
         loop_act_pkg::ST_SELFTEST, loop_act_pkg::ST_INACTIVE: begin
            swl_nxt = 1'b1;
            sigl_nxt = !LINE_END || !signalPresent;
         end
         loop_act_pkg::ST_ACTIVATING: begin
            sigl_nxt = 1'b0;
            if (frameSyncOk) begin
               swl_nxt = 1'b0;
            end
         end
         loop_act_pkg::ST_ACT_RX, loop_act_pkg::ST_ACT_TX, loop_act_pkg::ST_ACT_TXRX,
         loop_act_pkg::ST_PEND_DEACT: begin
            swl_nxt = !frameSyncOk;
         end
         loop_act_pkg::ST_DEACT: begin
            swl_nxt = LINE_END;
            sigl_nxt = !signalPresent;
         end
         default: begin
            swl_nxt = 1'b1;
         end
      endcase
   end

   // sticky timeouts, a set in the clearing cycle wins
   always_ff @(posedge mclk) begin
      if (srst) begin
         syncWordLost_r <= 1'b1;
         signalLost_r <= 1'b1;
         syncTo_r <= 1'b0;
         sigTo_r <= 1'b0;
      end else begin
         syncWordLost_r <= swl_nxt;
         signalLost_r <= sigl_nxt;
         syncTo_r <= (syncTo_r && !clrSyncTo) || pendExpire;
         sigTo_r <= (sigTo_r && !clrSigTo) || lossExpire;
      end
   end

   // ==========================================================
   // pair identity and response channel
   logic pairB_r, txB_r;
   wire markerA = markerFirst == loop_act_pkg::SYM_C && markerSecond == loop_act_pkg::SYM_D;
   wire markerB = markerFirst == loop_act_pkg::SYM_D && markerSecond == loop_act_pkg::SYM_C;
   always_ff @(posedge mclk) begin
      if (srst) begin
         pairB_r <= PAIR_IS_B;
         txB_r <= 1'b0;
      end else begin
         if (!LINE_END && markerValid && (markerA || markerB)) begin
            pairB_r <= markerB;
         end
         if (!LINE_END && state_r == loop_act_pkg::ST_INACTIVE && startupDetected) begin
            txB_r <= startupOnB;
         end
      end
   end

   // ==========================================================
   // transmit mode and indicators
   logic silent_r, startup_r, framed_r, ownInd_r, farInd_r;
   logic inActive;
   wire regenHold = IS_REGEN && !timingStable;
   assign inActive = state_nxt == loop_act_pkg::ST_ACT_TXRX ||
                     state_nxt == loop_act_pkg::ST_PEND_DEACT;
   always_ff @(posedge mclk) begin
      if (srst) begin
         silent_r <= 1'b1;
         startup_r <= 1'b0;
         framed_r <= 1'b0;
         ownInd_r <= 1'b0;
         farInd_r <= 1'b0;
      end else begin
         startup_r <= state_nxt == loop_act_pkg::ST_ACTIVATING && !frameSyncOk && !regenHold;
         framed_r <= inActive || state_nxt == loop_act_pkg::ST_ACT_RX ||
                     state_nxt == loop_act_pkg::ST_ACT_TX ||
                     (state_nxt == loop_act_pkg::ST_ACTIVATING && frameSyncOk);
         silent_r <= !(state_nxt == loop_act_pkg::ST_ACTIVATING && !regenHold) &&
                     !inActive && state_nxt != loop_act_pkg::ST_ACT_RX &&
                     state_nxt != loop_act_pkg::ST_ACT_TX;
         ownInd_r <= state_nxt == loop_act_pkg::ST_ACT_RX || inActive;
         farInd_r <= state_nxt == loop_act_pkg::ST_ACT_TX || inActive;
      end
   end

   assign stateOut = state_r;
   assign txSilent = silent_r;
   assign txStartup = startup_r;
   assign txFramed = framed_r;
   assign txOnB = txB_r;
   assign ownReadyInd = ownInd_r;
   assign farReadyInd = farInd_r;
   assign syncWordLost = syncWordLost_r;
   assign signalLost = signalLost_r;
   assign syncLossTimeoutFlag = syncTo_r;
   assign signalLossTimeoutFlag = sigTo_r;
   assign pairIsB = pairB_r;
   assign actTimerRunning = actRun_r;

   // ==========================================================
   // checks
   quiet_ignored_a: assert property (@(posedge mclk) disable iff (srst)
      state_r == loop_act_pkg::ST_INACTIVE && quietPulse && !(LINE_END && activationRequest) &&
      !(!LINE_END && startupDetected) |=> state_r == loop_act_pkg::ST_INACTIVE)
      else $error("silence command moved inactive state");
   quiet_deact_a: assert property (@(posedge mclk) disable iff (srst)
      quietPulse && state_r != loop_act_pkg::ST_INACTIVE && state_r != loop_act_pkg::ST_SELFTEST
      |=> state_r == loop_act_pkg::ST_DEACT)
      else $error("silence command did not deactivate");
   selftest_hold_a: assert property (@(posedge mclk) disable iff (srst)
      state_r == loop_act_pkg::ST_SELFTEST && !selfTestDone |=> state_r == loop_act_pkg::ST_SELFTEST)
      else $error("left power-up before self tests");
   ready_qual_a: assert property (@(posedge mclk) disable iff (srst)
      $rose(farReadyQ) |-> $past(frameStrobe) && $past(farReadyBit) && $past(readyCnt_r) == 3'h5)
      else $error("far ready qualified early");
   pend_timeout_a: assert property (@(posedge mclk) disable iff (srst)
      pendExpire && !quietPulse && !frameSyncOk |=> state_r == loop_act_pkg::ST_DEACT && syncTo_r)
      else $error("pending timeout not taken");
   txrx_timer_a: assert property (@(posedge mclk) disable iff (srst)
      state_r == loop_act_pkg::ST_ACT_TXRX |-> !actRun_r)
      else $error("activation timer runs in active state");
   inactive_flags_a: assert property (@(posedge mclk) disable iff (srst)
      state_r == loop_act_pkg::ST_INACTIVE && $past(state_r) == loop_act_pkg::ST_INACTIVE
      |-> syncWordLost_r && silent_r)
      else $error("inactive flags or transmitter wrong");
   line_start_a: assert property (@(posedge mclk) disable iff (srst)
      LINE_END && state_r == loop_act_pkg::ST_INACTIVE && activationRequest && !quietPulse
      |=> state_r == loop_act_pkg::ST_ACTIVATING ##0 !actRun_r)
      else $error("request did not start activation");
   deact_silent_a: assert property (@(posedge mclk) disable iff (srst)
      state_r == loop_act_pkg::ST_DEACT ##1 state_r == loop_act_pkg::ST_DEACT
      |-> silent_r && syncWordLost_r == LINE_END)
      else $error("deactivated state transmits or wrong sync flag");
endmodule // loop_activation_fsm

// >>> test/peer_model.sv
// Purpose: behavioural far-end transceiver on the copper pair
// Assumes: bench steers line power, frame sync and the far ready bit
// Notes: a frame arrives every eight mclk cycles while the line is powered
`timescale 1ns/10ps
module peer_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic txSilent,
   input wire logic linkUp,
   input wire logic syncOn,
   input wire logic farReady,
   output logic startupDetected,
   output logic frameSyncOk,
   output logic frameStrobe,
   output logic farReadyBit,
   output logic signalPresent
);
   logic [2:0] frameCnt_r;
   logic lastBit_r;
   // ==========================================================
   // frame timing and last ready bit sent
   always_ff @(posedge mclk) begin
      if (srst) begin
         frameCnt_r <= 3'h0;
         lastBit_r <= 1'b0;
      end else begin
         frameCnt_r <= frameCnt_r + 3'h1;
         if (frameStrobe) begin
            lastBit_r <= farReady;
         end
      end
   end
   // ==========================================================
   // line view: answers startup only while the block transmits
   assign signalPresent = linkUp;
   assign startupDetected = linkUp & ~txSilent;
   assign frameSyncOk = linkUp & syncOn;
   assign frameStrobe = linkUp & (frameCnt_r == 3'h7);
   // ready bit valid only with the strobe, scrambled between frames
   assign farReadyBit = frameStrobe ? farReady : ~lastBit_r;
endmodule // peer_model

// >>> test/loop_activation_fsm_test.sv
// Purpose: self-checking bench for the line-end activation state machine
// Assumes: short tick and timer parameters to keep the run brief
// Notes: each scenario is its own task; the run ends in wrapUp
`timescale 1ns/10ps
module loop_activation_fsm_test;
   localparam int TICK_C = 4;
   localparam int ACT_T = 50;
   localparam int PEND_T = 20;
   localparam int LOSS_T = 10;
   logic mclk, srst, regWr, regRd, selfTestDone, localReady, linkUp, syncOn, farReady, timingOk;
   logic [3:0] regAddr;
   logic [31:0] regWrData, regRdData, d;
   logic startupDetected, frameSyncOk, frameStrobe, farReadyBit, signalPresent;
   logic [7:0] stateOut;
   logic txSilent, txStartup, txFramed, ownReadyInd, farReadyInd, syncWordLost, signalLossTimeoutFlag;
   logic actTimerRunning;
   int miscompares = 0;
   int numChecks = 0;
   int n, frames;
   // ==========================================================
   // design and far end
   loop_activation_fsm #(.LINE_END(1'b1), .IS_REGEN(1'b1), .TICK_CYC(TICK_C), .ACT_TICKS(ACT_T),
      .PEND_TICKS(PEND_T), .LOSS_TICKS(LOSS_T)) i_dut (.mclk(mclk), .srst(srst), .regAddr(regAddr),
      .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .selfTestDone(selfTestDone),
      .startupDetected(startupDetected), .startupOnB(1'b0), .frameSyncOk(frameSyncOk),
      .frameStrobe(frameStrobe), .farReadyBit(farReadyBit), .localReady(localReady),
      .signalPresent(signalPresent), .timingStable(timingOk), .markerValid(1'b0), .markerFirst(2'h0),
      .markerSecond(2'h0), .stateOut(stateOut), .txSilent(txSilent), .txStartup(txStartup),
      .txFramed(txFramed), .txOnB(), .ownReadyInd(ownReadyInd), .farReadyInd(farReadyInd),
      .syncWordLost(syncWordLost), .signalLost(), .syncLossTimeoutFlag(),
      .signalLossTimeoutFlag(signalLossTimeoutFlag), .pairIsB(), .actTimerRunning(actTimerRunning));
   peer_model i_peer (.mclk(mclk), .srst(srst), .txSilent(txSilent), .linkUp(linkUp), .syncOn(syncOn),
      .farReady(farReady), .startupDetected(startupDetected), .frameSyncOk(frameSyncOk),
      .frameStrobe(frameStrobe), .farReadyBit(farReadyBit), .signalPresent(signalPresent));
   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrReg(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rdReg(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      v = regRdData;
   endtask
   task automatic waitState(input logic [7:0] exp, input int limit, output int cnt);
      cnt = 0;
      while (stateOut !== exp && cnt < limit) begin
         @(posedge mclk);
         #1;
         cnt++;
      end
   endtask
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_selftest;
      #1;
      check(stateOut, loop_act_pkg::ST_SELFTEST);
      wrReg(loop_act_pkg::CTRL_OFS, 32'h0000_0002);
      repeat (3) @(posedge mclk);
      #1;
      check(stateOut, loop_act_pkg::ST_SELFTEST);
      @(posedge mclk);
      selfTestDone <= 1'b1;
      waitState(loop_act_pkg::ST_INACTIVE, 4, n);
      check(stateOut, loop_act_pkg::ST_INACTIVE);
      wrReg(loop_act_pkg::CTRL_OFS, 32'h0000_0002);
      repeat (3) @(posedge mclk);
      #1;
      check(stateOut, loop_act_pkg::ST_INACTIVE);
      check({txSilent, syncWordLost}, 2'h3);
      $display("test selftest done");
   endtask
   task automatic t_activate;
      @(posedge mclk);
      linkUp <= 1'b1;
      wrReg(loop_act_pkg::CTRL_OFS, 32'h0000_0001);
      waitState(loop_act_pkg::ST_ACTIVATING, 4, n);
      check(stateOut, loop_act_pkg::ST_ACTIVATING);
      check({txStartup, txSilent}, 2'h1);
      @(posedge mclk);
      timingOk <= 1'b1;
      @(posedge mclk);
      #1;
      check({txStartup, txSilent}, 2'h2);
      @(posedge mclk);
      syncOn <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      check(actTimerRunning, 1'b1);
      check(syncWordLost, 1'b0);
      @(posedge mclk);
      farReady <= 1'b1;
      frames = 0;
      n = 0;
      #1;
      while (stateOut !== loop_act_pkg::ST_ACT_TX && n < 100) begin
         if (frameStrobe === 1'b1) frames++;
         @(posedge mclk);
         #1;
         n++;
      end
      check(stateOut, loop_act_pkg::ST_ACT_TX);
      check(frames, 6);
      check({ownReadyInd, farReadyInd}, 2'h1);
      @(posedge mclk);
      localReady <= 1'b1;
      waitState(loop_act_pkg::ST_ACT_TXRX, 4, n);
      check(stateOut, loop_act_pkg::ST_ACT_TXRX);
      check({actTimerRunning, txFramed}, 2'h1);
      $display("test activate done");
   endtask
   task automatic t_pending;
      @(posedge mclk);
      syncOn <= 1'b0;
      localReady <= 1'b0;
      waitState(loop_act_pkg::ST_PEND_DEACT, 4, n);
      check(stateOut, loop_act_pkg::ST_PEND_DEACT);
      check(txFramed, 1'b1);
      @(posedge mclk);
      syncOn <= 1'b1;
      waitState(loop_act_pkg::ST_ACT_TXRX, 4, n);
      check(stateOut, loop_act_pkg::ST_ACT_TXRX);
      @(posedge mclk);
      syncOn <= 1'b0;
      waitState(loop_act_pkg::ST_PEND_DEACT, 4, n);
      waitState(loop_act_pkg::ST_DEACT, PEND_T * TICK_C + 8, n);
      check(stateOut, loop_act_pkg::ST_DEACT);
      check(n >= (PEND_T - 1) * TICK_C, 1'b1);
      rdReg(loop_act_pkg::STAT_OFS, d);
      check(d[loop_act_pkg::STAT_SYNCTO], 1'b1);
      wrReg(loop_act_pkg::CTRL_OFS, 32'h0000_0005);
      rdReg(loop_act_pkg::STAT_OFS, d);
      check(d[loop_act_pkg::STAT_SYNCTO], 1'b0);
      $display("test pending done");
   endtask
   task automatic t_deact;
      check({txSilent, syncWordLost}, 2'h3);
      @(posedge mclk);
      linkUp <= 1'b0;
      waitState(loop_act_pkg::ST_INACTIVE, LOSS_T * TICK_C + 8, n);
      check(stateOut, loop_act_pkg::ST_INACTIVE);
      check(n >= (LOSS_T - 1) * TICK_C, 1'b1);
      check(signalLossTimeoutFlag, 1'b1);
      waitState(loop_act_pkg::ST_ACTIVATING, 4, n);
      check(stateOut, loop_act_pkg::ST_ACTIVATING);
      $display("test deact done");
   endtask
   task automatic t_quiet;
      wrReg(loop_act_pkg::CTRL_OFS, 32'h0000_0003);
      waitState(loop_act_pkg::ST_DEACT, 4, n);
      check(stateOut, loop_act_pkg::ST_DEACT);
      rdReg(loop_act_pkg::STAT_OFS, d);
      check(d[7:0], loop_act_pkg::ST_DEACT);
      check(d[loop_act_pkg::STAT_SIGL], 1'b1);
      rdReg(4'h8, d);
      check(d, 32'h0000_0000);
      wrReg(loop_act_pkg::CTRL_OFS, 32'h0000_0009);
      waitState(loop_act_pkg::ST_ACTIVATING, LOSS_T * TICK_C + 12, n);
      check(signalLossTimeoutFlag, 1'b1);
      @(posedge mclk);
      linkUp <= 1'b1;
      syncOn <= 1'b0;
      farReady <= 1'b0;
      waitState(loop_act_pkg::ST_DEACT, ACT_T * TICK_C + 16, n);
      check(stateOut, loop_act_pkg::ST_DEACT);
      check(n >= (ACT_T - 1) * TICK_C, 1'b1);
      $display("test quiet and expiry done");
   endtask
   task automatic t_rx;
      @(posedge mclk);
      linkUp <= 1'b0;
      waitState(loop_act_pkg::ST_ACTIVATING, LOSS_T * TICK_C + 12, n);
      @(posedge mclk);
      localReady <= 1'b1;
      waitState(loop_act_pkg::ST_ACT_RX, 4, n);
      check(stateOut, loop_act_pkg::ST_ACT_RX);
      check({ownReadyInd, farReadyInd}, 2'h2);
      @(posedge mclk);
      linkUp <= 1'b1;
      farReady <= 1'b1;
      waitState(loop_act_pkg::ST_ACT_TXRX, 80, n);
      check(stateOut, loop_act_pkg::ST_ACT_TXRX);
      check(n >= 5 * 8 + 2, 1'b1);
      $display("test rx path done");
   endtask
   // ==========================================================
   // clock, watchdog and main sequence
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      #40000;
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, stateOut, 8'h00);
      wrapUp;
   end
   initial begin
      srst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWrData = 32'h0000_0000;
      selfTestDone = 1'b0;
      localReady = 1'b0;
      linkUp = 1'b0;
      syncOn = 1'b0;
      farReady = 1'b0;
      timingOk = 1'b0;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      t_selftest;
      t_activate;
      t_pending;
      t_deact;
      t_quiet;
      t_rx;
      wrapUp;
   end
endmodule // loop_activation_fsm_test
